// File: design/mdsc_cfg.svh
// Constants of the motor driver serial control port.
`ifndef MDSC_CFG_SVH
`define MDSC_CFG_SVH
// ==========================================
// Word layout (12 bit control word)
`define MDSC_WORD_BITS 12
`define MDSC_MIN_BITS 12
`define MDSC_MDA_BIT 11
`define MDSC_DACA_HI 10
`define MDSC_DACA_LO 7
`define MDSC_PHA_BIT 6
`define MDSC_MDB_BIT 5
`define MDSC_DACB_HI 4
`define MDSC_DACB_LO 1
`define MDSC_PHB_BIT 0
`define MDSC_WORD_RESET 12'h000
// ==========================================
// Timing
`define MDSC_CLK_MHZ 100
`define MDSC_OSC_KHZ 25
`define MDSC_OSC_CYC ((`MDSC_CLK_MHZ * 1000) / `MDSC_OSC_KHZ)
`define MDSC_PD_US 3
`define MDSC_PD_CYC (`MDSC_PD_US * `MDSC_CLK_MHZ)
`define MDSC_LD_US 5
`define MDSC_LD_CYC (`MDSC_LD_US * `MDSC_CLK_MHZ)
`define MDSC_BLANK_NS 1500
`define MDSC_BLANK_CYC ((`MDSC_BLANK_NS * `MDSC_CLK_MHZ + 999) / 1000)
`endif

// File: design/mdsc_pkg.sv
// Types of the motor driver serial control port.
package mdsc_pkg;
	typedef enum logic [1:0] {
		MDSC_CH_OFF,
		MDSC_CH_BLANK,
		MDSC_CH_ON,
		MDSC_CH_WAIT
	} mdsc_chop_e;
endpackage

// File: design/mdsc_chopper.sv
// One coil's chopper and bridge gate drive.
`include "mdsc_cfg.svh"
module mdsc_chopper
	import mdsc_pkg::*;
#(
	parameter int DAC_W = 4,
	parameter int BLANK_CYC = `MDSC_BLANK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic enable,
	input wire logic [DAC_W-1:0] dac,
	input wire logic polarity,
	input wire logic restart,
	input wire logic period_start,
	input wire logic sense_trip,
	// Gates
	output logic high_gate_p,
	output logic low_gate_p,
	output logic high_gate_n,
	output logic low_gate_n
);
	mdsc_chop_e st_r, st_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	wire dac_zero = (dac == '0);
	wire on_w = enable && !dac_zero && (st_r == MDSC_CH_BLANK || st_r == MDSC_CH_ON);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			MDSC_CH_OFF: begin
				if (!dac_zero && enable && (period_start || restart)) begin
					st_nxt = sense_trip ? MDSC_CH_WAIT : MDSC_CH_BLANK;
					cnt_nxt = 16'h0000;
				end
			end
			MDSC_CH_BLANK: begin
				cnt_nxt = cnt_r + 16'h0001;
				if (cnt_r >= 16'(BLANK_CYC - 1))
					st_nxt = MDSC_CH_ON;
			end
			MDSC_CH_ON: begin
				if (sense_trip)
					st_nxt = MDSC_CH_WAIT;
			end
			MDSC_CH_WAIT: begin
				if (period_start)
					st_nxt = sense_trip ? MDSC_CH_WAIT : MDSC_CH_BLANK;
				cnt_nxt = 16'h0000;
			end
			default: st_nxt = MDSC_CH_OFF;
		endcase
		// A polarity change restarts only this coil's cycle.
		if (restart && st_r != MDSC_CH_OFF) begin
			st_nxt = sense_trip ? MDSC_CH_WAIT : MDSC_CH_BLANK;
			cnt_nxt = 16'h0000;
		end
		if (dac_zero || !enable)
			st_nxt = MDSC_CH_OFF;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= MDSC_CH_OFF;
			cnt_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// In the off time all four gates are off, the same as with dac zero.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			high_gate_p <= 1'b0;
			low_gate_p <= 1'b0;
			high_gate_n <= 1'b0;
			low_gate_n <= 1'b0;
		end else begin
			high_gate_p <= on_w && polarity;
			low_gate_n <= on_w && polarity;
			high_gate_n <= on_w && !polarity;
			low_gate_p <= on_w && !polarity;
		end
	end
endmodule

// File: design/mdsc_top.sv
// Serial control port of a dual full-bridge stepper driver.
// ==========================================
// How it works
// - Serial out is released whenever drive_disable_n or select_low is high.
// - A changed coil polarity restarts that coil's chopper cycle only.
// - A chopper period does not switch on while that coil's sense is already tripped.
// - A framed transfer shorter than 12 bits is dropped and settings stay.
// - In a 16 bit transfer the first 4 bits are dummies and fall out of the word.
// - Daisy chaining and separate selects both work, serial out carrying shifted bits.
// - A coil whose DAC field is zero has its bridge fully off.
// - The load indicator is valid within 7 us of a polarity change.
`include "mdsc_cfg.svh"
module mdsc_top
	import mdsc_pkg::*;
#(
	parameter int WORD_W = `MDSC_WORD_BITS,
	parameter int OSC_CYC = `MDSC_OSC_CYC,
	parameter int PD_CYC = `MDSC_PD_CYC,
	parameter int LD_CYC = `MDSC_LD_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Serial pins
	input wire logic drive_disable_n,
	input wire logic select_low,
	input wire logic serial_clk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// Coil sense comparators
	input wire logic coil_sense_a,
	input wire logic coil_sense_b,
	// Bridge gates
	output logic high_gate_a,
	output logic low_gate_a,
	output logic high_gate_a2,
	output logic low_gate_a2,
	output logic high_gate_b,
	output logic low_gate_b,
	output logic high_gate_b2,
	output logic low_gate_b2,
	// Status
	output logic [WORD_W-1:0] control_word,
	output logic load_valid
);
	// ==========================================
	// Input synchronisers
	logic [5:0] s1_r, s2_r;
	wire [5:0] raw_w = {drive_disable_n, select_low, serial_clk, serial_in,
		coil_sense_a, coil_sense_b};
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= 6'h30;
			s2_r <= 6'h30;
		end else begin
			s1_r <= raw_w;
			s2_r <= s1_r;
		end
	end
	wire dis_w = s2_r[5];
	wire sel_w = s2_r[4];
	wire sck_w = s2_r[3];
	wire sdi_w = s2_r[2];
	wire sense_a_w = s2_r[1];
	wire sense_b_w = s2_r[0];

	// ==========================================
	// Shift register
	logic sck_d_r, sel_d_r;
	logic [WORD_W-1:0] shift_r;
	logic [7:0] bits_r;
	logic sdo_r;
	wire active_w = !sel_w && !dis_w;
	wire sck_rise = sck_w && !sck_d_r && active_w;
	wire sck_fall = !sck_w && sck_d_r && active_w;
	wire sel_rise = sel_w && !sel_d_r;
	wire long_w = (bits_r >= 8'(`MDSC_MIN_BITS));
	wire accept_w = sel_rise && long_w && !dis_w;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sck_d_r <= 1'b0;
			sel_d_r <= 1'b1;
		end else begin
			sck_d_r <= sck_w;
			sel_d_r <= sel_w;
		end
	end

	// Older bits fall off the top, so dummies in a 16 bit frame vanish.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_r <= `MDSC_WORD_RESET;
			bits_r <= 8'h00;
		end else if (sel_w) begin
			bits_r <= 8'h00;
		end else if (sck_rise) begin
			shift_r <= {shift_r[WORD_W-2:0], sdi_w};
			if (bits_r != 8'hff)
				bits_r <= bits_r + 8'h01;
		end
	end

	// Serial out changes on the falling clock edge, showing the bit leaving the register.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			sdo_r <= 1'b0;
		else if (sel_w)
			sdo_r <= 1'b0;
		else if (sck_fall)
			sdo_r <= shift_r[WORD_W-1];
	end
	assign serial_out = sdo_r;
	// Release follows the synchronised pins, so serial out lets go two clocks after a pin rises.
	// Reading the raw pins here would put unsynchronised logic on the output enable.
	assign serial_out_oe = !dis_w && !sel_w;

	// ==========================================
	// Control word and delayed polarity
	logic [WORD_W-1:0] word_r;
	logic pha_r, phb_r, pha_pend_r, phb_pend_r;
	logic [15:0] pd_cnt_r;
	logic pend_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			word_r <= `MDSC_WORD_RESET;
		else if (accept_w)
			word_r <= shift_r;
	end
	assign control_word = word_r;

	// Polarity lands a fixed delay after select, well inside the allowed bound.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pend_r <= 1'b0;
			pd_cnt_r <= 16'h0000;
			pha_pend_r <= 1'b0;
			phb_pend_r <= 1'b0;
		end else if (accept_w) begin
			pend_r <= 1'b1;
			pd_cnt_r <= 16'h0000;
			pha_pend_r <= shift_r[`MDSC_PHA_BIT];
			phb_pend_r <= shift_r[`MDSC_PHB_BIT];
		end else if (pend_r) begin
			pd_cnt_r <= pd_cnt_r + 16'h0001;
			if (pd_cnt_r >= 16'(PD_CYC - 1))
				pend_r <= 1'b0;
		end
	end
	wire apply_w = pend_r && (pd_cnt_r >= 16'(PD_CYC - 1));
	wire chg_a_w = apply_w && (pha_pend_r != pha_r);
	wire chg_b_w = apply_w && (phb_pend_r != phb_r);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pha_r <= 1'b0;
			phb_r <= 1'b0;
		end else if (apply_w) begin
			pha_r <= pha_pend_r;
			phb_r <= phb_pend_r;
		end
	end

	// ==========================================
	// Oscillator divider and load indicator
	logic [15:0] osc_r;
	wire osc_tick = (osc_r == 16'(OSC_CYC - 1));
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			osc_r <= 16'h0000;
		else
			osc_r <= osc_tick ? 16'h0000 : osc_r + 16'h0001;
	end

	// The indicator is held low for a fixed settle time after any polarity change.
	logic [15:0] ld_cnt_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			ld_cnt_r <= 16'h0000;
		else if (chg_a_w || chg_b_w)
			ld_cnt_r <= 16'(LD_CYC);
		else if (ld_cnt_r != 16'h0000)
			ld_cnt_r <= ld_cnt_r - 16'h0001;
	end
	// A disabled drive reports no valid load, since its bridges are off.
	assign load_valid = (ld_cnt_r == 16'h0000) && !dis_w;

	// ==========================================
	// Coil choppers
	// Both coils share one period tick, so their chopper periods start together.
	wire en_w = !dis_w;
	mdsc_chopper u_chop_a (
		.clk(clk),
		.resetn(resetn),
		.enable(en_w),
		.dac(word_r[`MDSC_DACA_HI:`MDSC_DACA_LO]),
		.polarity(pha_r),
		.restart(chg_a_w),
		.period_start(osc_tick),
		.sense_trip(sense_a_w),
		.high_gate_p(high_gate_a),
		.low_gate_p(low_gate_a),
		.high_gate_n(high_gate_a2),
		.low_gate_n(low_gate_a2)
	);
	mdsc_chopper u_chop_b (
		.clk(clk),
		.resetn(resetn),
		.enable(en_w),
		.dac(word_r[`MDSC_DACB_HI:`MDSC_DACB_LO]),
		.polarity(phb_r),
		.restart(chg_b_w),
		.period_start(osc_tick),
		.sense_trip(sense_b_w),
		.high_gate_p(high_gate_b),
		.low_gate_p(low_gate_b),
		.high_gate_n(high_gate_b2),
		.low_gate_n(low_gate_b2)
	);
endmodule

// File: bench/mdsc_monitor.sv
// Checker of the motor driver serial control port.
module mdsc_monitor #(parameter int OSC_CYC = 4000, PD_CYC = 300, LD_CYC = 500) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Pins, coil A and status
	input wire logic drive_disable_n,
	input wire logic select_low,
	input wire logic serial_out_oe,
	input wire logic coil_sense_a,
	input wire logic high_gate_a,
	input wire logic low_gate_a,
	input wire logic high_gate_a2,
	input wire logic low_gate_a2,
	input wire logic [11:0] control_word,
	input wire logic load_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// Longest settle allowed after the first eight low cycles, at 100 MHz.
	localparam int LD_MAX = 690;
	logic [7:0] trip_r;
	logic a_off;
	assign a_off = !(high_gate_a | low_gate_a | high_gate_a2 | low_gate_a2);
	// Saturates, so a long trip never wraps back under the threshold.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trip_r <= 8'h00;
		end else begin
			trip_r <= coil_sense_a ? trip_r + {7'h00, ~&trip_r} : 8'h00;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence lv_settle;
		!load_valid [*8] ##[1:LD_MAX] load_valid;
	endsequence
	AST_SDO_OFF: assert property ((drive_disable_n || select_low) [*3] |-> !serial_out_oe)
		else $error("sdo driven");
	AST_QUIET: assert property (select_low && $past(select_low, 8) |-> $stable(control_word))
		else $error("word moved");
	AST_LATCH: assert property ($changed(control_word) |->
		$past(select_low, 2) && $past(select_low, 3)) else $error("early word");
	AST_DAC_ZERO: assert property ((control_word[10:7] == 4'h0) [*3] |-> a_off)
		else $error("coil on at zero");
	AST_NO_SHOOT: assert property (!(high_gate_a & low_gate_a | high_gate_a2 & low_gate_a2))
		else $error("shoot through");
	AST_POL_LOAD: assert property ($changed(control_word[6]) |-> ##[1:600] !load_valid)
		else $error("polarity lost");
	AST_LOAD: assert property ($fell(load_valid) && !drive_disable_n |-> lv_settle)
		else $error("load timing");
	AST_TRIP: assert property (trip_r > 8'ha0 |-> a_off) else $error("on while tripped");
endmodule
bind mdsc_top mdsc_monitor #(.OSC_CYC(OSC_CYC), .PD_CYC(PD_CYC), .LD_CYC(LD_CYC))
	mon_u (.*);

// File: bench/mdsc_host.sv
// Host model that frames and shifts control words.
module mdsc_host (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic select_low,
	output logic serial_clk,
	output logic serial_in,
	input wire logic serial_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] rx = 16'h0000;
	initial begin
		select_low = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
	end
	task automatic xfer(input logic [15:0] d, input int n);
		select_low = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_in = d[i];
			repeat (8) @(negedge clk);
			serial_clk = 1'b1;
			rx = {rx[14:0], serial_out};
			repeat (8) @(negedge clk);
			serial_clk = 1'b0;
		end
		repeat (4) @(negedge clk);
		select_low = 1'b1;
		// A released line shows the inverse, never a stale copy of the data.
		serial_in = ~serial_in;
		repeat (12) @(negedge clk);
	endtask
endmodule

// File: bench/tb.sv
// Testbench of the motor driver serial control port.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, drive_disable_n, coil_sense_a, coil_sense_b;
	wire select_low, serial_clk, serial_in, serial_out, serial_out_oe, load_valid;
	wire high_gate_a, low_gate_a, high_gate_a2, low_gate_a2;
	wire high_gate_b, low_gate_b, high_gate_b2, low_gate_b2;
	wire [11:0] control_word;
	wire [3:0] ga = {high_gate_a, low_gate_a2, high_gate_a2, low_gate_a};
	wire [3:0] gb = {high_gate_b, low_gate_b2, high_gate_b2, low_gate_b};
	int err_total = 0;
	int checks = 0;
	always #5 clk = ~clk;
	mdsc_host host_u (.*);
	mdsc_top #(.OSC_CYC(200), .PD_CYC(20), .LD_CYC(30)) dut_u (.*);
	task automatic check(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic t_word();
		fork
			host_u.xfer(16'h03c3, 12);
			begin
				repeat (40) @(negedge clk);
				check("oe on", serial_out_oe, 1'b1);
			end
		join
		check("oe off", serial_out_oe, 1'b0);
		check("word", control_word, 16'h03c3);
		repeat (20) @(negedge clk);
		check("gates a", ga, 4'hc);
		check("load low", load_valid, 1'b0);
		repeat (30) @(negedge clk);
		check("load high", load_valid, 1'b1);
	endtask
	task automatic t_disable();
		drive_disable_n = 1'b1;
		repeat (4) @(negedge clk);
		check("oe dis", serial_out_oe, 1'b0);
		check("load dis", load_valid, 1'b0);
		drive_disable_n = 1'b0;
		repeat (250) @(negedge clk);
		check("gates a back", ga, 4'hc);
		check("gates b back", gb, 4'hc);
		check("load back", load_valid, 1'b1);
	endtask
	task automatic t_pad();
		host_u.xfer(16'hd383, 16);
		check("pad word", control_word, 16'h0383);
		check("chain", host_u.rx[3:0], 4'hd);
		host_u.xfer(16'h0fff, 11);
		check("short", control_word, 16'h0383);
		check("gates a", ga, 4'h3);
		check("gates b", gb, 4'hc);
	endtask
	task automatic t_zero();
		host_u.xfer(16'h0043, 12);
		check("dac zero", ga, 4'h0);
		host_u.xfer(16'h03c3, 12);
		coil_sense_a = 1'b1;
		repeat (450) @(negedge clk);
		check("tripped", ga, 4'h0);
		coil_sense_a = 1'b0;
		repeat (450) @(negedge clk);
		check("rearmed", ga, 4'hc);
	endtask
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		drive_disable_n = 1'b0;
		coil_sense_a = 1'b0;
		coil_sense_b = 1'b0;
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		t_word();
		t_pad();
		t_zero();
		t_disable();
		final_report();
	end
	// The tests need about 2300 clk, so a run past 100 us has hung.
	initial begin
		#100us;
		err_total++;
		final_report();
	end
endmodule
